// ---- urx_consts.svh ----
// register map, field positions, reset values and sampling counts
`ifndef URX_CONSTS_SVH
`define URX_CONSTS_SVH

// ==========================================================
// register byte offsets
`define URX_OFF_CTRL 8'h00
`define URX_OFF_STAT 8'h04
`define URX_OFF_DATA 8'h08
`define URX_OFF_BAUD 8'h0c

// ==========================================================
// control register fields
`define URX_CTRL_REN 0
`define URX_CTRL_NINE 1
`define URX_CTRL_PREN 2
`define URX_CTRL_PODD 3
`define URX_CTRL_RIE 4
`define URX_CTRL_RX8 5

// ==========================================================
// status register fields
`define URX_STAT_AVAIL 0
`define URX_STAT_OVR 1
`define URX_STAT_NF 2
`define URX_STAT_FERR 3
`define URX_STAT_PERR 4
`define URX_STAT_IDLE 5

// ==========================================================
// reset values and timing
`define URX_BAUD_RST 8'h81
`define URX_CLK_HZ 20000000
`define URX_SMP_A 4'd7
`define URX_SMP_B 4'd8
`define URX_DECIDE 4'd9
`define URX_TICK_LAST 4'd15
`define URX_LAST_BIT8 4'd7
`define URX_LAST_BIT9 4'd8

`endif

// ---- urx_pkg.sv ----
// types shared by the receiver files
package urx_pkg;
   // receiver frame states
   typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_STOP} urx_state_e;
   // one received word, ninth bit on top
   typedef logic [8:0] urx_word_t;
endpackage

// ---- urx_fifo.sv ----
// two-entry receive word buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module urx_fifo
   import urx_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic push_i,
   input wire urx_word_t wdata_i,
   // drain side
   input wire logic pop_i,
   output urx_word_t rdata_o,
   // fill level
   output logic full_o,
   output logic empty_o,
   output logic [1:0] count_o
);
   // ==========================================================
   // storage and pointers
   urx_word_t mem_q [2]; // entries
   logic wp_q; // write index
   logic rp_q; // read index
   logic [1:0] cnt_q; // occupancy
   logic do_push; // accepted push
   logic do_pop; // accepted pop

   // full and empty refuse the matching side
   assign do_push = push_i & (cnt_q != 2'd2);
   assign do_pop = pop_i & (cnt_q != 2'd0);

   // one write port per entry
   for (genvar i = 0; i < 2; i++) begin : g_ent
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            mem_q[i] <= 9'h000;
         end else if (do_push && (wp_q == 1'(i))) begin
            mem_q[i] <= wdata_i;
         end
      end
   end

   // pointers and count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (do_push) wp_q <= ~wp_q;
         if (do_pop) rp_q <= ~rp_q;
         cnt_q <= 2'(cnt_q + {1'b0, do_push} - {1'b0, do_pop});
      end
   end

   assign rdata_o = mem_q[rp_q];
   assign full_o = (cnt_q == 2'd2);
   assign empty_o = (cnt_q == 2'd0);
   assign count_o = cnt_q;
endmodule
`default_nettype wire

// ---- urx_receiver.sv ----
// asynchronous serial receive path with apb register slave
// Notes on behaviour
// - words of 8 or 9 bits, ninth kept apart
// - recovery at sixteen ticks per bit
// - bit level by majority of three samples
// - shift lsb first, shifter hidden from software
// - after stop sample move word to buffer
// - buffer holds two words, third assembles
// - third word on full buffer: drop, overrun
// - enable starts hunting for start bit
// - data available while buffer not empty
// - interrupt on transfer or overrun, if enabled
// - available clears: status then data read
// - overrun clears: status then data read
// - break gives zero word with framing error
// - after break wait for high line
// - idle low from start until stop
// - noise flagged with the word, no interrupt
// - noise clears: status then data read
// - one stop bit checked, zero is framing
// - parity error against selected parity type
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
module urx_receiver
   import urx_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // serial line
   input wire logic rx_i,
   // interrupt request
   output logic irq_o
);
   // ==========================================================
   // reset release
   logic rst_meta_q; // first stage, read only by second
   logic rst_n_q; // synchronised reset

   // release through two flops, assert at once
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ==========================================================
   // apb decode
   logic acc; // access phase
   logic done; // completing edge
   logic hit_ctrl; // control hit
   logic hit_stat; // status hit
   logic hit_data; // data hit
   logic hit_baud; // divisor hit
   logic unmapped; // no register here
   logic stat_rd; // status read completes
   logic data_rd; // data read completes
   logic clr_seq; // data read after status
   logic [31:0] rd_mux; // read value

   assign acc = psel_i & penable_i;
   assign done = acc & pready_o;
   assign hit_ctrl = (paddr_i == `URX_OFF_CTRL);
   assign hit_stat = (paddr_i == `URX_OFF_STAT);
   assign hit_data = (paddr_i == `URX_OFF_DATA);
   assign hit_baud = (paddr_i == `URX_OFF_BAUD);
   assign unmapped = ~(hit_ctrl | hit_stat | hit_data | hit_baud);
   assign stat_rd = done & ~pwrite_i & hit_stat;
   assign data_rd = done & ~pwrite_i & hit_data;

   // ==========================================================
   // software controlled state
   logic ren_q; // receive_enable
   logic nine_q; // nine_bit_select
   logic pren_q; // parity_enable
   logic podd_q; // parity_type_select, 1 = odd
   logic rie_q; // rx_interrupt_enable
   logic [7:0] baud_q; // baud_divisor
   logic arm_q; // status seen, awaiting data read

   // writes take effect at the completing edge only
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ren_q <= 1'b0;
         nine_q <= 1'b0;
         pren_q <= 1'b0;
         podd_q <= 1'b0;
         rie_q <= 1'b0;
         baud_q <= `URX_BAUD_RST;
      end else if (done && pwrite_i) begin
         if (hit_ctrl) begin
            ren_q <= pwdata_i[`URX_CTRL_REN];
            nine_q <= pwdata_i[`URX_CTRL_NINE];
            pren_q <= pwdata_i[`URX_CTRL_PREN];
            podd_q <= pwdata_i[`URX_CTRL_PODD];
            rie_q <= pwdata_i[`URX_CTRL_RIE];
         end
         if (hit_baud) baud_q <= pwdata_i[7:0];
      end
   end

   // two-step clear: status read arms, data read fires
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         arm_q <= 1'b0;
      end else if (stat_rd) begin
         arm_q <= 1'b1;
      end else if (data_rd) begin
         arm_q <= 1'b0;
      end
   end
   assign clr_seq = data_rd & arm_q;

   // ==========================================================
   // oversampling tick
   logic [7:0] div_q; // divisor count
   logic tick_q; // one pulse per sixteenth of a bit

   // tick rate is clock / (divisor + 1), sixteen per bit
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (!ren_q) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == baud_q) begin
         div_q <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q <= 8'(div_q + 8'd1);
         tick_q <= 1'b0;
      end
   end

   // ==========================================================
   // receive state machine
   urx_state_e st_q; // frame state
   logic rx_q; // registered line
   logic [3:0] tcnt_q; // tick within bit
   logic [3:0] bit_q; // data bit index
   logic [1:0] smp_q; // first two samples
   urx_word_t sh_q; // rx_shift_register, not mapped
   logic noise_q; // disagreement in frame
   logic wait_hi_q; // must see high before hunt
   logic idle_q; // rx_idle_flag
   logic maj; // voted level
   logic disagree; // samples differ
   logic decide; // decision tick
   logic frame_done; // stop bit decided
   logic [3:0] last_bit; // last data index
   urx_word_t word; // aligned word

   // third sample is the live line at the decision tick
   assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rx_q)
              | (smp_q[1] & rx_q);
   assign disagree = ~((smp_q[0] == smp_q[1]) & (smp_q[1] == rx_q));
   assign decide = tick_q & (tcnt_q == `URX_DECIDE);
   assign frame_done = decide & (st_q == ST_STOP);
   assign last_bit = nine_q ? `URX_LAST_BIT9 : `URX_LAST_BIT8;
   // eight-bit words sit one place high after eight shifts
   assign word = nine_q ? sh_q : {1'b0, sh_q[8:1]};

   // line input is synchronous, one register suffices
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) rx_q <= 1'b1;
      else rx_q <= rx_i;
   end

   // frame sequencing
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= ST_HUNT;
         tcnt_q <= 4'd0;
         bit_q <= 4'd0;
         smp_q <= 2'b00;
         sh_q <= 9'h000;
         noise_q <= 1'b0;
         wait_hi_q <= 1'b1;
         idle_q <= 1'b1;
      end else if (!ren_q) begin
         // disabled: abandon frame, require high line later
         st_q <= ST_HUNT;
         wait_hi_q <= 1'b1;
         idle_q <= 1'b1;
      end else if (tick_q) begin
         case (st_q)
            ST_HUNT: begin
               if (rx_q) begin
                  wait_hi_q <= 1'b0;
               end else if (!wait_hi_q) begin
                  // falling edge: start bit begins
                  st_q <= ST_START;
                  tcnt_q <= 4'd1;
                  bit_q <= 4'd0;
                  noise_q <= 1'b0;
                  idle_q <= 1'b0;
               end
            end
            default: begin
               tcnt_q <= 4'(tcnt_q + 4'd1);
               if (tcnt_q == `URX_SMP_A || tcnt_q == `URX_SMP_B) begin
                  smp_q <= {smp_q[0], rx_q};
               end
               if (tcnt_q == `URX_DECIDE) begin
                  noise_q <= noise_q | disagree;
                  if (st_q == ST_START && maj) begin
                     // glitch, not a start bit
                     st_q <= ST_HUNT;
                     idle_q <= 1'b1;
                  end else if (st_q == ST_DATA) begin
                     sh_q <= {maj, sh_q[8:1]};
                  end else if (st_q == ST_STOP) begin
                     // one stop bit only; low stop blocks hunt
                     st_q <= ST_HUNT;
                     idle_q <= 1'b1;
                     wait_hi_q <= ~maj;
                  end
               end
               if (tcnt_q == `URX_TICK_LAST) begin
                  if (st_q == ST_START) begin
                     st_q <= ST_DATA;
                  end else if (st_q == ST_DATA) begin
                     bit_q <= 4'(bit_q + 4'd1);
                     if (bit_q == last_bit) st_q <= ST_STOP;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // receive buffer
   urx_word_t head; // oldest word
   logic full; // both entries used
   logic empty; // nothing held
   logic [1:0] count; // occupancy
   logic push; // word accepted
   logic overrun; // word dropped

   assign push = frame_done & ~full;
   assign overrun = frame_done & full;

   urx_fifo u_fifo (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_q),
      .push_i(push),
      .wdata_i(word),
      .pop_i(data_rd),
      .rdata_o(head),
      .full_o(full),
      .empty_o(empty),
      .count_o(count)
   );

   // ==========================================================
   // status flags, a set in the clearing cycle wins
   logic avail_q; // rx_data_available_flag
   logic ovr_q; // overrun_flag
   logic nf_q; // noise_flag
   logic fe_q; // framing_error_flag
   logic pe_q; // parity_error_flag

   // data available follows arrivals, drops once drained
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) avail_q <= 1'b0;
      else if (push) avail_q <= 1'b1;
      else if (clr_seq && count == 2'd1) avail_q <= 1'b0;
   end

   // overrun keeps buffer contents, only flags the loss
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) ovr_q <= 1'b0;
      else if (overrun) ovr_q <= 1'b1;
      else if (clr_seq) ovr_q <= 1'b0;
   end

   // per-word error flags rise with data available
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         nf_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
      end else if (push) begin
         nf_q <= nf_q | noise_q | disagree;
         fe_q <= fe_q | ~maj;
         pe_q <= pe_q | (pren_q & (^word ^ podd_q));
      end else if (clr_seq) begin
         nf_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
      end
   end

   // one-cycle request; noise has no source of its own
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) irq_o <= 1'b0;
      else irq_o <= rie_q & (push | overrun);
   end

   // ==========================================================
   // apb answer: one wait state, data captured on the edge that raises ready
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`URX_CTRL_REN] = ren_q;
         rd_mux[`URX_CTRL_NINE] = nine_q;
         rd_mux[`URX_CTRL_PREN] = pren_q;
         rd_mux[`URX_CTRL_PODD] = podd_q;
         rd_mux[`URX_CTRL_RIE] = rie_q;
         rd_mux[`URX_CTRL_RX8] = head[8] & ~empty;
      end else if (hit_stat) begin
         rd_mux[`URX_STAT_AVAIL] = avail_q;
         rd_mux[`URX_STAT_OVR] = ovr_q;
         rd_mux[`URX_STAT_NF] = nf_q;
         rd_mux[`URX_STAT_FERR] = fe_q;
         rd_mux[`URX_STAT_PERR] = pe_q;
         rd_mux[`URX_STAT_IDLE] = idle_q;
      end else if (hit_data) begin
         rd_mux[7:0] = empty ? 8'h00 : head[7:0];
      end else if (hit_baud) begin
         rd_mux[7:0] = baud_q;
      end
   end

   // ready rises in the second access cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= acc & ~pready_o;
         pslverr_o <= acc & ~pready_o & unmapped;
         if (acc && !pready_o) prdata_o <= pwrite_i ? 32'h0 : rd_mux;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_q);

   sequence s_start_seen;
      (st_q == ST_HUNT) && tick_q && !rx_q && !wait_hi_q && ren_q;
   endsequence
   sequence s_bit_decided;
      tick_q && ren_q && (st_q == ST_DATA) && (tcnt_q == `URX_DECIDE);
   endsequence

   property p_idle_drop;
      s_start_seen |=> !idle_q && (st_q == ST_START);
   endproperty
   a_idle_drop: assert property (p_idle_drop)
      else $error("idle not low after start");

   property p_lsb_shift;
      s_bit_decided |=> sh_q[8] == $past(maj);
   endproperty
   a_lsb_shift: assert property (p_lsb_shift)
      else $error("shift bit not voted value");

   property p_push_avail;
      push |=> avail_q && idle_q;
   endproperty
   a_push_avail: assert property (p_push_avail)
      else $error("available or idle wrong after push");

   property p_overrun;
      // a pop in the same cycle would legally lower the count
      overrun && !data_rd |=> ovr_q && (count == 2'd2)
         && (irq_o == $past(rie_q));
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun handling wrong");

   property p_irq_push;
      push && rie_q |=> irq_o ##1 !irq_o;
   endproperty
   a_irq_push: assert property (p_irq_push)
      else $error("interrupt not a single pulse");

   property p_avail_fall;
      $fell(avail_q) |-> $past(clr_seq);
   endproperty
   a_avail_fall: assert property (p_avail_fall)
      else $error("available cleared without sequence");

   property p_break_frame;
      frame_done && !maj && !full |=> fe_q && avail_q && wait_hi_q;
   endproperty
   a_break_frame: assert property (p_break_frame)
      else $error("low stop not handled as break");

   property p_hold_low;
      ren_q && wait_hi_q && !rx_q && (st_q == ST_HUNT) |=> st_q == ST_HUNT;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("low line taken as start");

   property p_noise;
      // noise anywhere in the frame, stop bit included
      push && (noise_q || disagree) |=> nf_q && avail_q;
   endproperty
   a_noise: assert property (p_noise)
      else $error("noise flag not raised with word");
endmodule
`default_nettype wire

// ---- urx_line_model.sv ----
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module urx_line_model (
   // bench clock
   input wire logic clk_i,
   // serial line, idle high
   output var logic rx_o
);
   // ==========================================================
   // frame generator
   initial rx_o = 1'b1;
   // one frame: start, nb bits lsb first, stop level stp; gl inverts one
   // tick in the middle of data bit gl (negative: none); xl keeps the
   // line low longer
   task automatic send(input logic [8:0] w, input int nb, input int dv,
         input logic stp, input int gl, input int xl);
      logic [10:0] fr;
      int per;
      fr = {1'b1, w, 1'b0};
      fr[nb + 1] = stp;
      per = 16 * (dv + 1);
      for (int i = 0; i < nb + 2 + xl; i++) begin
         for (int k = 0; k < per; k++) begin
            @(posedge clk_i);
            // past the stop bit a break keeps the line low
            rx_o <= (i > nb + 1) ? 1'b0 :
               fr[i] ^ (gl >= 0 && i == gl + 1 && k / (dv + 1) == 9);
         end
      end
      // back to idle high, held two bit times
      @(posedge clk_i);
      rx_o <= 1'b1;
      repeat (2 * per) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ---- urx_receiver_tb.sv ----
// self-checking bench for the serial receive path
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
n_mismatch++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module urx_receiver_tb;
   // ==========================================================
   // signals and counters
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rx, irq;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_irq = 0;
   int cyc = 0;
   logic [32:0] expq[$]; // expected {slverr, data} of each read
   logic [32:0] ev;
   logic [31:0] seed = 32'h2678;
   // status and control bit weights
   localparam logic [31:0] AV = 32'h1 << `URX_STAT_AVAIL;
   localparam logic [31:0] OV = 32'h1 << `URX_STAT_OVR;
   localparam logic [31:0] NF = 32'h1 << `URX_STAT_NF;
   localparam logic [31:0] FE = 32'h1 << `URX_STAT_FERR;
   localparam logic [31:0] PE = 32'h1 << `URX_STAT_PERR;
   localparam logic [31:0] ID = 32'h1 << `URX_STAT_IDLE;
   localparam logic [31:0] CEN = 32'h1 << `URX_CTRL_REN;
   localparam logic [31:0] CNI = 32'h1 << `URX_CTRL_NINE;
   localparam logic [31:0] CPR = 32'h1 << `URX_CTRL_PREN;
   localparam logic [31:0] CPO = 32'h1 << `URX_CTRL_PODD;
   localparam logic [31:0] CIE = 32'h1 << `URX_CTRL_RIE;
   always #25 clk = ~clk;
   urx_receiver uut (.ref_clk_i(clk), .resetn_i(rst_n), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .rx_i(rx), .irq_o(irq));
   urx_line_model line (.clk_i(clk), .rx_o(rx));
   // ==========================================================
   // watcher: irq pulses, read results, hang limit
   always @(posedge clk) begin
      cyc++;
      if (irq === 1'b1)
         n_irq++;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         ev = (expq.size() > 0) ? expq.pop_front() : 33'h1ffffffff;
         `CHK("prdata", ev, {pslverr, prdata})
      end
      if (cyc == 20000) begin
         n_mismatch++;
         $display("FAIL timeout exp %h got %h", 0, cyc);
         final_report();
      end
   end
   // ==========================================================
   // helpers
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   // one apb transfer; the edge wait keeps transfers one cycle apart
   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request stands until ready is sampled high at a rising edge
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic se = 1'b0);
      expq.push_back({se, e});
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic endt(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] b, c, d;
      logic [31:0] ctl;
      logic q;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(`URX_OFF_CTRL, 32'h0);
      rd(`URX_OFF_STAT, ID);
      rd(`URX_OFF_BAUD, {24'h0, `URX_BAUD_RST});
      rd(`URX_OFF_DATA, 32'h0);
      rd(8'h10, 32'h0, 1'b1);
      wr(`URX_OFF_BAUD, 32'h0);
      line.send(9'h0a5, 8, 0, 1'b1, -1, 0);
      rd(`URX_OFF_STAT, ID);
      endt("reset");
      // two words, status read in mid-frame
      wr(`URX_OFF_CTRL, CEN | CIE);
      rd(`URX_OFF_CTRL, CEN | CIE);
      b = rnd();
      c = rnd();
      fork
         line.send({1'b0, b}, 8, 0, 1'b1, -1, 0);
         begin
            repeat (80) @(posedge clk);
            rd(`URX_OFF_STAT, 32'h0);
         end
      join
      line.send({1'b0, c}, 8, 0, 1'b1, -1, 0);
      rd(`URX_OFF_STAT, AV | ID);
      rd(`URX_OFF_DATA, {24'h0, b});
      rd(`URX_OFF_STAT, AV | ID);
      rd(`URX_OFF_DATA, {24'h0, c});
      rd(`URX_OFF_STAT, ID);
      endt("receive");
      // third word on a full buffer is dropped
      b = rnd();
      c = rnd();
      d = rnd();
      line.send({1'b0, b}, 8, 0, 1'b1, -1, 0);
      line.send({1'b0, c}, 8, 0, 1'b1, -1, 0);
      line.send({1'b0, d}, 8, 0, 1'b1, -1, 0);
      rd(`URX_OFF_STAT, AV | OV | ID);
      rd(`URX_OFF_DATA, {24'h0, b});
      rd(`URX_OFF_STAT, AV | ID);
      rd(`URX_OFF_DATA, {24'h0, c});
      rd(`URX_OFF_STAT, ID);
      endt("overrun");
      // long break, line stays low past the stop position
      line.send(9'h000, 8, 0, 1'b0, -1, 8);
      rd(`URX_OFF_STAT, AV | FE | ID);
      rd(`URX_OFF_DATA, 32'h0);
      rd(`URX_OFF_STAT, ID);
      endt("break");
      // nine-bit words with even then odd parity
      for (int p = 0; p < 2; p++) begin
         ctl = CEN | CNI | CPR | ((p == 1) ? (CPO | CIE) : 32'h0);
         wr(`URX_OFF_CTRL, ctl);
         b = rnd();
         q = p[0] ^ (^b);
         line.send({q, b}, 9, 0, 1'b1, -1, 0);
         rd(`URX_OFF_CTRL, ctl | ({31'h0, q} << `URX_CTRL_RX8));
         rd(`URX_OFF_STAT, AV | ID);
         rd(`URX_OFF_DATA, {24'h0, b});
         line.send({~q, b}, 9, 0, 1'b1, -1, 0);
         rd(`URX_OFF_STAT, AV | PE | ID);
         rd(`URX_OFF_DATA, {24'h0, b});
      end
      endt("parity");
      // slower rate, one disturbed sample in a data bit
      wr(`URX_OFF_CTRL, CEN | CIE);
      wr(`URX_OFF_BAUD, 32'h3);
      b = rnd();
      line.send({1'b0, b}, 8, 3, 1'b1, 2, 0);
      rd(`URX_OFF_STAT, AV | NF | ID);
      rd(`URX_OFF_DATA, {24'h0, b});
      rd(`URX_OFF_STAT, ID);
      endt("noise");
      repeat (4) @(posedge clk);
      `CHK("irq count", 9, n_irq)
      final_report();
   end
endmodule
`default_nettype wire
